/* File: src/timer_pkg.sv */
/*
 * Constants, field layouts and carrier types for the three-channel
 * timer block: register offsets, control bit positions, reset values
 * and the clock ratio between the fast clock and the slow count rate.
 * Assumes a single 100 MHz clock that serves as the fast internal clock.
 */
package timer_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int unsigned NUM_TIMERS   = 3;   // Timer blocks.
    localparam int unsigned COUNT_W      = 16;  // Counter and reload width.
    localparam int unsigned ADDR_W       = 8;   // Register bus address width.
    localparam int unsigned DATA_W       = 16;  // Register bus data width.
    localparam int unsigned CTRL_W       = 8;   // Control register width.

    // ------------------------------------------------------------
    // Clock ratio: fast clock cycles per instruction cycle.
    // ------------------------------------------------------------
    localparam int unsigned INSTR_DIV    = 10;

    // ------------------------------------------------------------
    // Register map (byte offsets)
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] TIMER_STRIDE   = 8'h10;  // Spacing of timer blocks.
    localparam logic [3:0]        OFS_CTRL       = 4'h0;   // Control and flags.
    localparam logic [3:0]        OFS_COUNT      = 4'h4;   // Down counter.
    localparam logic [3:0]        OFS_RELOAD_A   = 4'h8;   // reload_capture_a.
    localparam logic [3:0]        OFS_RELOAD_B   = 4'hc;   // reload_capture_b.
    localparam logic [ADDR_W-1:0] OFS_SPEED_SEL  = 8'h30;  // timer_speed_select.

    // ------------------------------------------------------------
    // Control register bit positions
    // ------------------------------------------------------------
    localparam int unsigned BIT_RUN      = 0;   // run_or_underflow_flag.
    localparam int unsigned BIT_MODE1    = 1;   // mode_select_bit1.
    localparam int unsigned BIT_MODE2    = 2;   // mode_select_bit2.
    localparam int unsigned BIT_MODE3    = 3;   // mode_select_bit3.
    localparam int unsigned BIT_ENA      = 4;   // irq_enable_a.
    localparam int unsigned BIT_PNDA     = 5;   // pending_flag_a.
    localparam int unsigned BIT_ENB      = 6;   // irq_enable_b.
    localparam int unsigned BIT_PNDB     = 7;   // pending_flag_b.

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [CTRL_W-1:0]  CTRL_RESET  = 8'h00;
    localparam logic [COUNT_W-1:0] COUNT_RESET = 16'h0000;
    localparam logic [7:0]         SPEED_RESET = 8'h00;

    // Per-timer software view, carried to the read multiplexer.
    typedef struct packed {
        logic [CTRL_W-1:0]  ctrl;
        logic [COUNT_W-1:0] count;
        logic [COUNT_W-1:0] reload_a;
        logic [COUNT_W-1:0] reload_b;
    } timer_view_s;

endpackage

/* File: src/triple_timer_pwm_capture.sv */
/*
 * Three 16-bit down-counting timer blocks, timer one slow only, with PWM, external
 * event counting and dual-edge input capture, behind a simple register
 * port. Assumes timer pins arrive asynchronously and that the register
 * master issues one-cycle strobes on the same clock.
 */
// The plain strobed port and the register offsets are this design's own decisions.
`timescale 1ns/1ns
module triple_timer_pwm_capture
    import timer_pkg::*;
#(
    parameter int unsigned DIV = INSTR_DIV  // Fast cycles per instruction cycle.
) (
    // Clock and reset.
    input  wire logic                     clk,
    input  wire logic                     arst_n,
    // Register port.
    input  wire logic [ADDR_W-1:0]        addr,
    input  wire logic [DATA_W-1:0]        wr_data,
    input  wire logic                     wr_en,
    input  wire logic                     rd_en,
    output logic      [DATA_W-1:0]        rd_data,
    // Timer pins, one bit per timer block.
    input  wire logic [NUM_TIMERS-1:0]    timer_pin_a_in,
    output logic      [NUM_TIMERS-1:0]    timer_pin_a_out,
    output logic      [NUM_TIMERS-1:0]    timer_pin_a_oe_n,
    input  wire logic [NUM_TIMERS-1:0]    timer_pin_b_in,
    // Interrupt requests per timer and source.
    output logic      [NUM_TIMERS-1:0]    irq_a,
    output logic      [NUM_TIMERS-1:0]    irq_b
);

    // ------------------------------------------------------------
    // Instruction cycle enable
    // ------------------------------------------------------------
    logic [7:0]  div_count;       // Divider position.
    logic        instr_tick;      // One-cycle pulse at instruction rate.
    logic [7:0]  speed_sel;       // timer_speed_select register.
    timer_view_s view [NUM_TIMERS];  // Software view of each timer.

    // The slow rate is a pulse rather than a derived clock so the
    // whole block stays in one clock domain.
    // The first pulse comes DIV cycles after reset.
    // A slow timer started at once may wait a
    // whole instruction cycle for its first count.
    // The pulse is registered, so every timer
    // sees it on the same clock edge.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            div_count  <= 8'h00;
            instr_tick <= 1'b0;
        end else if (div_count == 8'(DIV - 1)) begin
            div_count  <= 8'h00;
            instr_tick <= 1'b1;
        end else begin
            div_count  <= div_count + 8'h01;
            instr_tick <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Speed select register
    // ------------------------------------------------------------
    // Only the two select bits are stored; the upper bits read zero.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            speed_sel <= SPEED_RESET;
        end else if (wr_en && addr == OFS_SPEED_SEL) begin
            speed_sel <= {6'h00, wr_data[1:0]};
        end
    end

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [NUM_TIMERS-1:0] a_meta;   // First stage, read only by a_sync.
    logic [NUM_TIMERS-1:0] a_sync;   // Second stage.
    logic [NUM_TIMERS-1:0] b_meta;   // First stage, read only by b_sync.
    logic [NUM_TIMERS-1:0] b_sync;   // Second stage.

    // Two flip-flops before any logic sees the pins.
    // This costs two cycles of latency on every edge.
    // Capture values on a fast timer are therefore two counts late,
    // but both pins pay the same, so the difference
    // between two captures is exact.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            a_meta <= '0;
            a_sync <= '0;
            b_meta <= '0;
            b_sync <= '0;
        end else begin
            a_meta <= timer_pin_a_in;
            a_sync <= a_meta;
            b_meta <= timer_pin_b_in;
            b_sync <= b_meta;
        end
    end

    // ------------------------------------------------------------
    // Timer blocks
    // ------------------------------------------------------------
    for (genvar i = 0; i < NUM_TIMERS; i++) begin : g_timer
        logic [CTRL_W-1:0]  ctrl;        // Control and flags.
        logic [COUNT_W-1:0] count;       // Down counter.
        logic [COUNT_W-1:0] reload_a;    // reload_capture_a.
        logic [COUNT_W-1:0] reload_b;    // reload_capture_b.
        logic               next_is_b;   // Next PWM reload comes from B.
        logic               a_prev;      // Pin A sampled at the last tick.
        logic               b_prev;      // Pin B sampled at the last tick.
        logic               pin_out;     // Driven level of pin A.
        logic               tick;        // Count rate pulse for this timer.
        logic               sel_fast;    // Timer uses the fast clock.
        logic               mode_pwm;    // Mode bits 10x.
        logic               mode_event;  // Mode bits 00x.
        logic               mode_cap;    // Mode bits x1x.
        logic               a_edge;      // Selected edge seen on pin A.
        logic               b_edge;      // Selected edge seen on pin B.
        logic               underflow;   // Counter passes through zero now.
        logic               set_pnda;    // Hardware sets pending A.
        logic               set_pndb;    // Hardware sets pending B.
        logic               set_run;     // Capture underflow flag set.
        logic               base_hit;    // Address falls in this block.
        logic               wr_ctrl;     // Write to control.
        logic               wr_count;    // Write to counter.
        logic               wr_ra;       // Write to reload A.
        logic               wr_rb;       // Write to reload B.

        // Timer one has no fast option; two and three follow their bit.
        // A generate branch keeps the select index in range.
        if (i == 0) begin : g_slow_only
            assign sel_fast = 1'b0;
        end else begin : g_speed_bit
            assign sel_fast = speed_sel[i-1];
        end
        assign tick     = sel_fast | instr_tick;

        // Mode decode from mode bits 2 and 3.
        assign mode_pwm   = ctrl[BIT_MODE3] & ~ctrl[BIT_MODE2];
        assign mode_event = ~ctrl[BIT_MODE3] & ~ctrl[BIT_MODE2];
        assign mode_cap   = ctrl[BIT_MODE2];

        // Edges are judged between samples taken at the count rate, so
        // a pulse shorter than one count period may go unseen.
        always_comb begin
            if (mode_cap) begin
                // Bit 1 picks the pin A polarity, bit 3 the pin B one.
                a_edge = ctrl[BIT_MODE1] ? (a_prev & ~a_sync[i])
                                         : (~a_prev & a_sync[i]);
                b_edge = ctrl[BIT_MODE3] ? (b_prev & ~b_sync[i])
                                         : (~b_prev & b_sync[i]);
            end else begin
                a_edge = ctrl[BIT_MODE1] ? (a_prev & ~a_sync[i])
                                         : (~a_prev & a_sync[i]);
                b_edge = ~b_prev & b_sync[i];
            end
        end

        // Underflow condition for each mode.
        // PWM needs the run bit; capture ignores it,
        // since there it is the underflow flag.
        // Event counting underflows only on an edge
        // that finds the counter already at zero.
        always_comb begin
            if (mode_cap) begin
                underflow = tick && count == '0;
            end else if (mode_event) begin
                underflow = tick && ctrl[BIT_RUN] && a_edge
                            && count == '0;
            end else begin
                underflow = tick && ctrl[BIT_RUN] && count == '0;
            end
        end

        // Hardware flag events.
        always_comb begin
            set_pnda = 1'b0;
            set_pndb = 1'b0;
            set_run  = 1'b0;
            if (mode_pwm) begin
                set_pnda = underflow && !next_is_b;
                set_pndb = underflow && next_is_b;
            end else if (mode_event) begin
                set_pnda = underflow;
                set_pndb = tick && b_edge;
            end else begin
                set_pnda = tick && a_edge;
                set_pndb = tick && b_edge;
                set_run  = underflow;
            end
        end

        // Register decode for this block.
        assign base_hit = addr[ADDR_W-1:4] == 4'(i);
        assign wr_ctrl  = wr_en && base_hit && addr[3:0] == OFS_CTRL;
        assign wr_count = wr_en && base_hit && addr[3:0] == OFS_COUNT;
        assign wr_ra    = wr_en && base_hit && addr[3:0] == OFS_RELOAD_A;
        assign wr_rb    = wr_en && base_hit && addr[3:0] == OFS_RELOAD_B;

        // Pin samples for edge detection, updated at the count rate.
        always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
                a_prev <= 1'b0;
                b_prev <= 1'b0;
            end else if (tick) begin
                a_prev <= a_sync[i];
                b_prev <= b_sync[i];
            end
        end

        // Control register. A write may land in any mode at any speed;
        // hardware flag sets are ORed after the write so they survive.
        // A read-modify-write from software may
        // therefore see a flag it meant to clear
        // come back; that event was real, not lost.
        always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
                ctrl <= CTRL_RESET;
            end else begin
                ctrl <= (wr_ctrl ? wr_data[CTRL_W-1:0] : ctrl)
                        | (CTRL_W'(set_pnda) << BIT_PNDA)
                        | (CTRL_W'(set_pndb) << BIT_PNDB)
                        | (CTRL_W'(set_run) << BIT_RUN);
            end
        end

        // PWM reload sequence: a stopped timer always restarts on A.
        always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
                next_is_b <= 1'b0;
            end else if (!mode_pwm || !ctrl[BIT_RUN]) begin
                next_is_b <= 1'b0;
            end else if (underflow) begin
                next_is_b <= ~next_is_b;
            end
        end

        // Down counter. A software write takes priority over counting.
        // A write while a fast timer runs lands, but
        // the count it replaces may already be stale;
        // stop the timer first for a clean change.
        // Capture wraps from zero to all ones.
        always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
                count <= COUNT_RESET;
            end else if (wr_count) begin
                count <= wr_data;
            end else if (underflow && mode_pwm) begin
                count <= next_is_b ? reload_b : reload_a;
            end else if (underflow && mode_event) begin
                count <= reload_a;
            end else if (mode_cap && tick) begin
                count <= count - 16'h0001;
            end else if (mode_event && tick && ctrl[BIT_RUN] && a_edge) begin
                count <= count - 16'h0001;
            end else if (mode_pwm && tick && ctrl[BIT_RUN]) begin
                count <= count - 16'h0001;
            end
        end

        // Reload / capture register A. A capture beats a software write
        // so that a measurement is never dropped.
        always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
                reload_a <= COUNT_RESET;
            end else if (mode_cap && tick && a_edge) begin
                reload_a <= count;
            end else if (wr_ra) begin
                reload_a <= wr_data;
            end
        end

        // Reload / capture register B.
        always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
                reload_b <= COUNT_RESET;
            end else if (mode_cap && tick && b_edge) begin
                reload_b <= count;
            end else if (wr_rb) begin
                reload_b <= wr_data;
            end
        end

        // Pin A drive. Only PWM drives it; other modes release it so
        // it can act as an input.
        // The level is kept across mode changes, so
        // a new PWM run starts from the old level.
        always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
                pin_out <= 1'b0;
            end else if (mode_pwm && underflow && ctrl[BIT_MODE1]) begin
                pin_out <= ~pin_out;
            end
        end

        always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
                timer_pin_a_out[i]  <= 1'b0;
                timer_pin_a_oe_n[i] <= 1'b1;
            end else begin
                timer_pin_a_out[i]  <= pin_out;
                timer_pin_a_oe_n[i] <= ~mode_pwm;
            end
        end

        // Interrupt requests follow flag and enable.
        // They are levels, one cycle behind the flags,
        // and drop only when software clears the flag
        // or the enable.
        always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
                irq_a[i] <= 1'b0;
                irq_b[i] <= 1'b0;
            end else begin
                irq_a[i] <= ctrl[BIT_ENA] & (ctrl[BIT_PNDA]
                            | (mode_cap & ctrl[BIT_RUN]));
                irq_b[i] <= ctrl[BIT_ENB] & ctrl[BIT_PNDB];
            end
        end

        assign view[i] = '{ctrl: ctrl, count: count, reload_a: reload_a, reload_b: reload_b};
    end

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    // Reads have no side effects, so a capture register can be read
    // while the counter keeps running.
    // Data stand for one cycle after the strobe and
    // read zero at every other time, so a slave
    // that never stalls needs no valid signal.
    // Unmapped offsets read zero as well.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_data <= '0;
        end else if (rd_en) begin
            rd_data <= '0;                                         // Unmapped reads zero.
            if (addr == OFS_SPEED_SEL) begin
                rd_data <= {8'h00, speed_sel};
            end
            for (int t = 0; t < NUM_TIMERS; t++) begin
                if (addr[ADDR_W-1:4] == 4'(t)) begin
                    unique case (addr[3:0])
                        OFS_CTRL:     rd_data <= {8'h00, view[t].ctrl};
                        OFS_COUNT:    rd_data <= view[t].count;
                        OFS_RELOAD_A: rd_data <= view[t].reload_a;
                        OFS_RELOAD_B: rd_data <= view[t].reload_b;
                        default:      rd_data <= '0;
                    endcase
                end
            end
        end else begin
            rd_data <= '0;
        end
    end

endmodule

/* File: verification/timer_pin_model.sv */
/*
 * Far-side model of the three timer pin pairs.
 * Assumes the bench calls pulse; the model never moves a pin by itself.
 */
`timescale 1ns/1ns
module timer_pin_model
    import timer_pkg::*;
(
    // Clock.
    input  wire logic                  clk,
    // Pin A drive from the block.
    input  wire logic [NUM_TIMERS-1:0] pin_a_out,
    input  wire logic [NUM_TIMERS-1:0] pin_a_oe_n,
    // Levels seen by the block.
    output logic      [NUM_TIMERS-1:0] pin_a_in,
    output logic      [NUM_TIMERS-1:0] pin_b_in
);
    logic [NUM_TIMERS-1:0] ext_a = '0;  // Level the model puts on pin A.

    // The block wins the shared pin A wherever it enables its driver.
    always_comb pin_a_in = (~pin_a_oe_n & pin_a_out) | (pin_a_oe_n & ext_a);
    initial pin_b_in = '0;

    // High then low for hold cycles each, longer than one count period.
    task automatic pulse(input int t, input bit b, input int hold);
        @(posedge clk);
        if (b) pin_b_in[t] <= 1'b1;
        else ext_a[t] <= 1'b1;
        repeat (hold) @(posedge clk);
        if (b) pin_b_in[t] <= 1'b0;
        else ext_a[t] <= 1'b0;
        repeat (hold) @(posedge clk);
    endtask
endmodule

/* File: verification/timer_asserts.sv */
/*
 * Port-level checker for the timer block.
 * Assumes it is bound to the top module; shadows the control of timer one.
 */
`timescale 1ns/1ns
module timer_asserts
    import timer_pkg::*;
(
    input wire logic              clk,
    input wire logic              arst_n,
    input wire logic [7:0]        addr,
    input wire logic [15:0]       wr_data,
    input wire logic              wr_en,
    input wire logic              rd_en,
    input wire logic [15:0]       rd_data,
    input wire logic [2:0]        timer_pin_a_out,
    input wire logic [2:0]        timer_pin_a_oe_n,
    input wire logic [2:0]        irq_a,
    input wire logic [2:0]        irq_b
);
    logic [7:0] sh;  // Software copy of timer one's control; mode and enables are software-only.
    logic       pwm;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) sh <= 8'h00;
        else if (wr_en && addr == 8'h00) sh <= wr_data[7:0];
    end
    assign pwm = sh[3] & ~sh[2];

    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);

    AST_RD_IDLE: assert property (!$past(rd_en) |-> rd_data == 16'h0000)
        else $error("read data not zero outside read");
    AST_SPEED_HI: assert property ($past(rd_en) && $past(addr) == 8'h30 |-> rd_data[15:2] == '0)
        else $error("speed select upper bits not zero");
    AST_UNMAPPED: assert property ($past(rd_en) && $past(addr) == 8'h3c |-> rd_data == 16'h0000)
        else $error("unmapped read not zero");
    AST_NO_OE: assert property (!pwm [*3] |-> timer_pin_a_oe_n[0])
        else $error("pin A driven outside pwm");
    AST_IRQA_OFF: assert property (!sh[4] [*3] |-> !irq_a[0])
        else $error("irq a without enable");
    AST_IRQB_OFF: assert property (!sh[6] [*3] |-> !irq_b[0])
        else $error("irq b without enable");
    AST_HOLD: assert property ((sh[3:1] == 3'b100) [*4] |-> $stable(timer_pin_a_out[0]))
        else $error("pin toggled in plain pwm");
    AST_IRQB_FALL: assert property ($fell(irq_b[0]) |-> $past(wr_en) || $past(wr_en, 2) || $past(wr_en, 3))
        else $error("pending b cleared without software");
endmodule

/* File: verification/tb.sv */
/*
 * Self-checking bench for the triple timer: registers, pwm, events, capture.
 * Assumes the timer package and the pin model are compiled first.
 */
`timescale 1ns/1ns
module tb
    import timer_pkg::*;
;
    localparam int DIV = 2;  // Short instruction tick keeps the run brief.
    logic              clk = 1'b0, arst_n = 1'b0, wr_en = 1'b0, rd_en = 1'b0;
    logic [7:0]        addr = '0;
    logic [15:0]       wr_data = '0, rd_data, got, ra, rb;
    logic [2:0]        pa_in, pa_out, pa_oe_n, pb_in, irq_a, irq_b;
    logic [31:0]       seed = 32'd72;
    int                n_fail = 0, checked = 0, cyc = 0, n;

    always #5 clk = ~clk;
    triple_timer_pwm_capture #(.DIV(DIV)) triple_timer_pwm_capture_inst (.clk(clk),
        .arst_n(arst_n), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
        .rd_data(rd_data), .timer_pin_a_in(pa_in), .timer_pin_a_out(pa_out),
        .timer_pin_a_oe_n(pa_oe_n), .timer_pin_b_in(pb_in), .irq_a(irq_a), .irq_b(irq_b));
    timer_pin_model timer_pin_model_inst (.clk(clk), .pin_a_out(pa_out),
        .pin_a_oe_n(pa_oe_n), .pin_a_in(pa_in), .pin_b_in(pb_in));

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [7:0] ad(input int t, input logic [3:0] o);
        return 8'(16 * t) | {4'h0, o};
    endfunction
    // Cycles between pwm toggles: timer two alone runs fast here.
    function automatic logic [15:0] pwm_gap(input int t, input logic [15:0] r);
        return 16'(((t == 1) ? 1 : DIV) * (r + 1));
    endfunction
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        checked++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 d = rd_data;
    endtask
    // Cycles until pin A of timer t changes, bounded.
    task automatic gap(input int t, output int c);
        logic v;
        v = pa_out[t];
        c = 0;
        while (pa_out[t] === v && c < 4000) begin
            @(negedge clk);
            c++;
        end
    endtask

    // Hang guard: the whole run needs well under a thousand cycles.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            print_verdict();
        end
    end

    initial begin
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        rd(8'h30, got); chk(got, 16'h0000);
        rd(8'h00, got); chk(got, 16'h0000);
        wr(8'h30, 16'hffff); rd(8'h30, got); chk(got, 16'h0003);
        rd(8'h3c, got); chk(got, 16'h0000);
        wr(8'h30, 16'h0001);
        for (int t = 0; t < 3; t++) begin
            ra = 16'(xs() % 8 + 1);
            rb = 16'(xs() % 8 + 1);
            // Reloads change only while stopped.
            wr(ad(t, 4'h8), ra); wr(ad(t, 4'hc), rb); wr(ad(t, 4'h4), 16'h0001);
            wr(ad(t, 4'h0), 16'h005b);
            gap(t, n);
            gap(t, n); chk(16'(n), pwm_gap(t, ra));
            gap(t, n); chk(16'(n), pwm_gap(t, rb));
            chk({14'h0, irq_a[t], irq_b[t]}, 16'h0003);
            rd(ad(t, 4'h0), got); chk(got, 16'h00fb);
            wr(ad(t, 4'h0), 16'h0000);
        end
        ra = {15'h0, pa_out[0]};
        wr(8'h04, 16'h0001); wr(8'h00, 16'h0019); repeat (40) @(posedge clk);
        chk({15'h0, pa_out[0]}, ra);
        rd(8'h00, got); chk(got, 16'h00b9);
        for (int m = 0; m < 2; m++) begin
            wr(8'h00, 16'h0000); wr(8'h08, 16'h0005); wr(8'h04, 16'h0002);
            wr(8'h00, 16'(8'h51 | 2 * m));
            repeat (3) timer_pin_model_inst.pulse(0, 1'b0, 8);
            timer_pin_model_inst.pulse(0, 1'b1, 8);
            rd(8'h04, got); chk(got, 16'h0005);
            rd(8'h00, got); chk(got, 16'(8'hf1 | 2 * m));
            chk({13'h0, pa_oe_n[0], irq_a[0], irq_b[0]}, 16'h0007);
        end
        wr(8'h00, 16'h0000); wr(8'h30, 16'h0003);
        for (int m = 0; m < 4; m++) begin
            wr(8'h20, 16'h0000); wr(8'h24, 16'h8000);
            wr(8'h20, 16'(8'h04 | 2 * m[0] | 8 * m[1]));
            timer_pin_model_inst.pulse(2, 1'b0, 8);
            timer_pin_model_inst.pulse(2, 1'b1, 8);
            rd(8'h28, ra); rd(8'h2c, rb);
            chk(ra - rb, 16'(17 + 8 * m[1] - 8 * m[0]));
            rd(8'h20, got); chk(got, 16'(8'ha4 | 2 * m[0] | 8 * m[1]));
            chk({14'h0, irq_a[2], irq_b[2]}, 16'h0000);
        end
        wr(8'h20, 16'h0004); wr(8'h24, 16'h0004); repeat (12) @(posedge clk);
        rd(8'h20, got); chk(got, 16'h0005);
        wr(8'h20, 16'h0015); repeat (3) @(posedge clk);
        chk({15'h0, irq_a[2]}, 16'h0001);
        print_verdict();
    end
endmodule

bind triple_timer_pwm_capture timer_asserts timer_asserts_inst (.clk(clk), .arst_n(arst_n),
    .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .timer_pin_a_out(timer_pin_a_out), .timer_pin_a_oe_n(timer_pin_a_oe_n),
    .irq_a(irq_a), .irq_b(irq_b));
